// ==== rtl/ebrh_top.sv ====
// external bus cycle control: strobes, waitstates, ready and hold arbitration
module ebrh_top #(
    parameter int NCS    = ebrh_pkg::NCS,
    parameter int ADDR_W = ebrh_pkg::ADDR_W,
    parameter int DATA_W = ebrh_pkg::DATA_W,
    parameter int XR_AW  = ebrh_pkg::ONCHIP_EXT_RAM_AW
) (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       reset_n,
    // configuration
    input  wire ebrh_pkg::ebrh_cfg_s [NCS-1:0] bus_config_reg,
    input  wire logic                       periph_share_mode,
    // internal request side
    input  wire logic                       req_valid,
    input  wire ebrh_pkg::ebrh_req_s        req,
    output logic                            req_ready,
    output logic                            resp_valid,
    output logic [DATA_W-1:0]               resp_rdata,
    // bus pins
    output logic                            bus_ref_clock,
    output logic [ADDR_W-1:0]               addr_out,
    output logic                            bus_oe,
    output logic [DATA_W-1:0]               data_out,
    output logic                            data_oe,
    input  wire logic [DATA_W-1:0]          data_in,
    output logic                            ale,
    output logic                            rd_n,
    output logic                            wr_n,
    output logic                            write_high_strobe_n,
    output logic                            write_low_strobe_n,
    output logic [NCS-1:0]                  write_chip_select_n,
    output logic [NCS-1:0]                  chip_select_n,
    input  wire logic                       ready_n,
    // arbitration
    input  wire logic                       hold_n,
    output logic                            hold_ack_out_n,
    output logic                            bus_request_out_n,
    // external master access to extension ram
    input  wire logic [XR_AW-1:0]           xm_addr,
    input  wire logic                       xm_rd_n,
    input  wire logic                       xm_wr_n,
    input  wire logic [DATA_W-1:0]          xm_wdata,
    output logic [DATA_W-1:0]               xm_rdata,
    output logic                            xm_data_oe
);
    ebrh_pkg::ebrh_state_e state_ff;
    ebrh_pkg::ebrh_cfg_s   cfg_ff;
    ebrh_pkg::ebrh_req_s   cur_ff;
    logic                  phase_ff;
    logic [ebrh_pkg::WAIT_W-1:0] wait_cnt_ff;
    logic                  first_smp_ff;
    logic                  first_cmd_ff;
    logic [3:0]            rel_cnt_ff;
    logic                  rdy_sync_n;
    logic                  rdy_low;
    logic                  cmd_done;
    logic                  tick;
    logic                  cmd_on;
    logic                  wr_on;
    logic                  xm_wr_n_ff;
    logic                  xm_wr_en;
    logic                  in_share;
    // registered pins
    logic                  req_ready_ff, resp_valid_ff, bus_oe_ff, data_oe_ff, ale_ff;
    logic                  rd_n_ff, wr_n_ff, wrh_n_ff, wrl_n_ff, hold_ack_n_ff, bus_request_out_n_ff;
    logic                  xm_data_oe_ff;
    logic [DATA_W-1:0]     resp_rdata_ff, data_out_ff;
    logic [ADDR_W-1:0]     addr_ff;
    logic [NCS-1:0]        cs_n_ff, write_chip_select_n_n_ff;

    // reference period is two internal clocks; bus cycle states move at its end, hold states do not wait for it
    assign tick = phase_ff;

    // extra sync stage for asynchronous ready
    ebrh_sync #(.W(1), .RST_VAL(1'b1)) u_rdy_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (ready_n),
        .sync_out (rdy_sync_n)
    );

    // ready sample: direct in sync mode, resynchronised in async mode
    assign rdy_low = cfg_ff.ready_async ? !rdy_sync_n : !ready_n;

    // command ends when waits are spent and ready permits it
    always_comb begin
        cmd_done = 1'b0;
        if (wait_cnt_ff == ebrh_pkg::WAIT_ZERO) begin
            if (!cfg_ff.ready_en) begin
                cmd_done = 1'b1;
            end else if (cfg_ff.ready_async && first_smp_ff) begin
                cmd_done = 1'b0;
            end else begin
                cmd_done = rdy_low;
            end
        end
    end

    // strobe shaping at half period grain
    always_comb begin
        cmd_on = (state_ff == ebrh_pkg::ST_CMD);
        if (cmd_on && first_cmd_ff && !phase_ff && cfg_ff.rw_delay_sel) begin
            cmd_on = 1'b0;
        end
        wr_on = cmd_on && cur_ff.write;
        if (wr_on && phase_ff && cmd_done && cfg_ff.early_write_en) begin
            wr_on = 1'b0;
        end
    end

    // reference clock phase
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            phase_ff <= 1'b0;
        end else begin
            phase_ff <= !phase_ff;
        end
    end

    // main cycle and arbitration sequencer
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_ff <= ebrh_pkg::ST_IDLE;
        end else begin
            unique case (state_ff)
                ebrh_pkg::ST_IDLE: begin
                    if (!hold_n) begin
                        state_ff <= ebrh_pkg::ST_CSREL;
                    end else if (tick && req_valid) begin
                        state_ff <= ebrh_pkg::ST_ADDR;
                    end
                end
                ebrh_pkg::ST_ADDR: begin
                    if (tick) begin
                        state_ff <= ebrh_pkg::ST_CMD;
                    end
                end
                ebrh_pkg::ST_CMD: begin
                    if (tick && cmd_done) begin
                        if (cfg_ff.mux_mode) begin
                            state_ff <= ebrh_pkg::ST_MUXW;
                        end else if (cfg_ff.tristate_wait_sel) begin
                            state_ff <= ebrh_pkg::ST_TRI;
                        end else begin
                            state_ff <= ebrh_pkg::ST_IDLE;
                        end
                    end
                end
                ebrh_pkg::ST_MUXW: begin
                    if (tick) begin
                        state_ff <= cfg_ff.tristate_wait_sel ? ebrh_pkg::ST_TRI
                                                             : ebrh_pkg::ST_IDLE;
                    end
                end
                ebrh_pkg::ST_TRI: begin
                    if (tick) begin
                        state_ff <= ebrh_pkg::ST_IDLE;
                    end
                end
                ebrh_pkg::ST_CSREL: begin
                    if (rel_cnt_ff == ebrh_pkg::REL_ONE) begin
                        state_ff <= ebrh_pkg::ST_HOLD;
                    end
                end
                ebrh_pkg::ST_HOLD: begin
                    if (hold_n) begin
                        state_ff <= ebrh_pkg::ST_REGAIN;
                    end
                end
                ebrh_pkg::ST_REGAIN: begin
                    state_ff <= ebrh_pkg::ST_IDLE;
                end
                default: begin
                    state_ff <= ebrh_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // request capture, per-cycle config and wait counting
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cur_ff       <= '0;
            cfg_ff       <= '0;
            wait_cnt_ff  <= ebrh_pkg::WAIT_ZERO;
            first_smp_ff <= 1'b0;
            first_cmd_ff <= 1'b0;
        end else begin
            if (state_ff == ebrh_pkg::ST_IDLE && hold_n && tick && req_valid) begin
                cur_ff <= req;
                cfg_ff <= bus_config_reg[req.cs];
            end
            if (state_ff == ebrh_pkg::ST_ADDR && tick) begin
                wait_cnt_ff  <= cfg_ff.mem_cycle_wait_count;
                first_smp_ff <= 1'b1;
                first_cmd_ff <= 1'b1;
            end else if (state_ff == ebrh_pkg::ST_CMD && tick) begin
                first_cmd_ff <= 1'b0;
                if (wait_cnt_ff != ebrh_pkg::WAIT_ZERO) begin
                    wait_cnt_ff <= wait_cnt_ff - 1'b1;
                end else begin
                    first_smp_ff <= 1'b0;
                end
            end
        end
    end

    // half period counter for chip select release
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rel_cnt_ff <= ebrh_pkg::REL_LOAD;
        end else if (state_ff == ebrh_pkg::ST_CSREL) begin
            rel_cnt_ff <= rel_cnt_ff - 1'b1;
        end else begin
            rel_cnt_ff <= ebrh_pkg::REL_LOAD;
        end
    end

    // bus pins; chip selects stay high while released, drivers off in hold
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            bus_oe_ff   <= 1'b1;
            addr_ff     <= '0;
            ale_ff      <= 1'b0;
            rd_n_ff     <= 1'b1;
            wr_n_ff     <= 1'b1;
            wrh_n_ff    <= 1'b1;
            wrl_n_ff    <= 1'b1;
            write_chip_select_n_n_ff   <= '1;
            cs_n_ff     <= '1;
            data_out_ff <= '0;
            data_oe_ff  <= 1'b0;
        end else begin
            bus_oe_ff <= !(state_ff == ebrh_pkg::ST_HOLD ||
                           (state_ff == ebrh_pkg::ST_CSREL &&
                            rel_cnt_ff == ebrh_pkg::REL_ONE));
            addr_ff   <= cur_ff.addr;
            ale_ff    <= (state_ff == ebrh_pkg::ST_ADDR) && cfg_ff.mux_mode && !phase_ff;
            rd_n_ff   <= !(cmd_on && !cur_ff.write);
            wr_n_ff   <= !wr_on;
            wrh_n_ff  <= !(wr_on && cur_ff.be[ebrh_pkg::BE_HI]);
            wrl_n_ff  <= !(wr_on && cur_ff.be[ebrh_pkg::BE_LO]);
            for (int i = 0; i < NCS; i++) begin
                cs_n_ff[i]   <= !((state_ff == ebrh_pkg::ST_ADDR ||
                                   state_ff == ebrh_pkg::ST_CMD) &&
                                  cur_ff.cs == i[ebrh_pkg::CS_W-1:0]);
                write_chip_select_n_n_ff[i] <= !(wr_on && cur_ff.cs == i[ebrh_pkg::CS_W-1:0]);
            end
            data_out_ff <= cur_ff.wdata;
            data_oe_ff  <= (state_ff == ebrh_pkg::ST_CMD) && cur_ff.write;
        end
    end

    // arbitration outputs; ack follows the float, drops before redrive
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            hold_ack_n_ff <= 1'b1;
            bus_request_out_n_ff     <= 1'b1;
        end else begin
            hold_ack_n_ff <= !(state_ff == ebrh_pkg::ST_HOLD && !bus_oe_ff && !hold_n);
            bus_request_out_n_ff     <= !(state_ff == ebrh_pkg::ST_HOLD && req_valid);
        end
    end

    // internal handshake and read data return
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            req_ready_ff  <= 1'b0;
            resp_valid_ff <= 1'b0;
            resp_rdata_ff <= '0;
        end else begin
            // ready is a one cycle take pulse, raised on the capture edge
            req_ready_ff  <= state_ff == ebrh_pkg::ST_IDLE && hold_n && tick && req_valid;
            resp_valid_ff <= state_ff == ebrh_pkg::ST_CMD && tick && cmd_done;
            if (state_ff == ebrh_pkg::ST_CMD && tick && cmd_done && !cur_ff.write) begin
                resp_rdata_ff <= data_in;
            end
        end
    end

    // shared extension ram: writes commit on the write strobe rising edge
    assign in_share = periph_share_mode && state_ff == ebrh_pkg::ST_HOLD && !bus_oe_ff;
    assign xm_wr_en = in_share && !xm_wr_n_ff && xm_wr_n;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            xm_wr_n_ff    <= 1'b1;
            xm_data_oe_ff <= 1'b0;
        end else begin
            xm_wr_n_ff    <= xm_wr_n;
            xm_data_oe_ff <= in_share && !xm_rd_n;
        end
    end

    ebrh_onchip_ext_ram #(.AW(XR_AW), .DW(DATA_W)) u_onchip_ext_ram (
        .sys_clk (sys_clk),
        .wr_en   (xm_wr_en),
        .wr_addr (xm_addr),
        .wr_data (xm_wdata),
        .rd_addr (xm_addr),
        .rd_data (xm_rdata)
    );

    // pin drive
    assign bus_ref_clock       = phase_ff;
    assign addr_out            = addr_ff;
    assign bus_oe              = bus_oe_ff;
    assign data_out            = data_out_ff;
    assign data_oe             = data_oe_ff;
    assign ale                 = ale_ff;
    assign rd_n                = rd_n_ff;
    assign wr_n                = wr_n_ff;
    assign write_high_strobe_n = wrh_n_ff;
    assign write_low_strobe_n  = wrl_n_ff;
    assign write_chip_select_n = write_chip_select_n_n_ff;
    assign chip_select_n       = cs_n_ff;
    assign hold_ack_out_n      = hold_ack_n_ff;
    assign bus_request_out_n   = bus_request_out_n_ff;
    assign req_ready           = req_ready_ff;
    assign resp_valid          = resp_valid_ff;
    assign resp_rdata          = resp_rdata_ff;
    assign xm_data_oe          = xm_data_oe_ff;

    a_ack_floated: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !hold_ack_out_n |-> !bus_oe) else $error("hold ack while bus driven");
    a_cycle_done_first: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_ff == ebrh_pkg::ST_CMD |=> state_ff != ebrh_pkg::ST_CSREL)
        else $error("bus released inside a cycle");
    a_cs_high_rel: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(state_ff == ebrh_pkg::ST_CSREL) |-> (&chip_select_n && bus_oe) ##1 !bus_oe)
        else $error("chip selects not driven high before float");
    a_regain_start: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_ff == ebrh_pkg::ST_HOLD && hold_n |=> hold_ack_out_n ##1 bus_oe)
        else $error("regain sequence not started");
    a_regain_nobreq: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_ff == ebrh_pkg::ST_HOLD && hold_n && bus_request_out_n
        |=> state_ff == ebrh_pkg::ST_REGAIN) else $error("no regain without request");
    a_mux_waitstate: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_ff == ebrh_pkg::ST_CMD && tick && cmd_done && cfg_ff.mux_mode
        |=> state_ff == ebrh_pkg::ST_MUXW [*2]) else $error("mux waitstate missing");
    a_demux_nodelay: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_ff == ebrh_pkg::ST_CMD && tick && cmd_done &&
        !cfg_ff.mux_mode && !cfg_ff.tristate_wait_sel |=> state_ff == ebrh_pkg::ST_IDLE)
        else $error("demux cycle delayed");
    a_tri_waitstate: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_ff == ebrh_pkg::ST_MUXW && tick && cfg_ff.tristate_wait_sel
        |=> state_ff == ebrh_pkg::ST_TRI) else $error("tristate waitstate missing");
    a_async_minwait: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_ff == ebrh_pkg::ST_CMD && tick && cfg_ff.ready_en && cfg_ff.ready_async &&
        first_smp_ff |=> state_ff == ebrh_pkg::ST_CMD) else $error("async ready no waitstate");
    a_wait_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_ff == ebrh_pkg::ST_CMD && tick && wait_cnt_ff != ebrh_pkg::WAIT_ZERO
        |=> state_ff == ebrh_pkg::ST_CMD) else $error("programmed wait skipped");
    a_ready_term: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_ff == ebrh_pkg::ST_CMD && tick && wait_cnt_ff == ebrh_pkg::WAIT_ZERO &&
        cfg_ff.ready_en && !cfg_ff.ready_async && !ready_n
        |=> state_ff != ebrh_pkg::ST_CMD) else $error("low ready did not end cycle");
endmodule

// ==== pkg/ebrh_pkg.sv ====
// constants, types and state codes of the external bus ready/hold control
package ebrh_pkg;
    // bus geometry
    localparam int NCS      = 4;
    localparam int CS_W     = 2;
    localparam int ADDR_W   = 24;
    localparam int DATA_W   = 16;
    localparam int WAIT_W   = 4;
    localparam int ONCHIP_EXT_RAM_AW  = 11;
    // timing: internal clock and one half reference period
    localparam int SYS_CLK_PERIOD_NS = 4;
    localparam int TCL_NS            = 4;
    localparam int TCL_RAW           = TCL_NS / SYS_CLK_PERIOD_NS;
    localparam int TCL_CYC           = (TCL_RAW < 1) ? 1 : TCL_RAW;
    // reset and compare values of the wait and release counters
    localparam logic [WAIT_W-1:0] WAIT_ZERO = 4'h0;
    localparam logic [3:0]        REL_ONE   = 4'h1;
    localparam logic [3:0]        REL_LOAD  = 4'(TCL_CYC);
    // byte enable lanes
    localparam int BE_LO = 0;
    localparam int BE_HI = 1;

    // per chip select bus configuration
    typedef struct packed {
        logic              rw_delay_sel;       // 1: command falls one half period late
        logic              early_write_en;     // 1: write strobe rises one half period early
        logic [WAIT_W-1:0] mem_cycle_wait_count;
        logic              tristate_wait_sel;
        logic              mux_mode;           // 1: multiplexed address/data
        logic              ready_en;           // 1: cycle ends by ready input
        logic              ready_async;        // 1: ready passes extra sync stage
    } ebrh_cfg_s;

    // one captured request of the internal side
    typedef struct packed {
        logic              write;
        logic [CS_W-1:0]   cs;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0]        be;
    } ebrh_req_s;

    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_ADDR   = 8'h02,
        ST_CMD    = 8'h04,
        ST_MUXW   = 8'h08,
        ST_TRI    = 8'h10,
        ST_CSREL  = 8'h20,
        ST_HOLD   = 8'h40,
        ST_REGAIN = 8'h80
    } ebrh_state_e;
endpackage

// ==== rtl/ebrh_sync.sv ====
// two-stage synchroniser for asynchronous level inputs
module ebrh_sync #(
    parameter int  W         = 1,
    parameter logic RST_VAL  = 1'b1
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    // level in and out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            meta_ff <= {W{RST_VAL}};
            sync_ff <= {W{RST_VAL}};
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule

// ==== rtl/ebrh_onchip_ext_ram.sv ====
// on-chip extension ram with registered read data
module ebrh_onchip_ext_ram #(
    parameter int AW = 11,
    parameter int DW = 16
) (
    // clock
    input  wire logic          sys_clk,
    // write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // read port
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] rd_data_ff;

    // no reset on the array; contents are undefined at power up
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_ff <= mem[rd_addr];
    end

    assign rd_data = rd_data_ff;
endmodule

// ==== test/ebrh_mem_model.sv ====
// external memory and ready source standing at the bus pins
module ebrh_mem_model (
    // bus pins seen
    input  wire logic        sys_clk,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [23:0] addr_out,
    input  wire logic [15:0] data_out,
    // command clocks before ready goes low
    input  wire logic [3:0]  rdy_dly,
    // answers
    output logic      [15:0] data_in,
    output logic             ready_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0;
    logic [3:0]  cnt  = 4'h0;
    initial ready_n = 1'h1;
    // write data taken when the strobe rises
    always @(posedge wr_n) mem[addr_out[3:0]] = data_out;
    // a released data bus shows the inverse of the last read, never a stale match
    always @(posedge rd_n) last = mem[addr_out[3:0]];
    assign data_in = !rd_n ? mem[addr_out[3:0]] : ~last;
    // ready moves in step with the clock, dropped once the command rises
    always @(posedge sys_clk) begin
        cnt <= (rd_n && wr_n) ? 4'h0 : cnt + 4'h1;
        ready_n <= #1 !(!(rd_n && wr_n) && cnt >= rdy_dly);
    end
endmodule

// ==== test/ebrh_top_test.sv ====
// self-checking bench of the bus cycle and hold control
module ebrh_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'h0;
    logic reset_n, req_valid, hold_n, xm_rd_n, xm_wr_n, req_ready, resp_valid, bus_oe;
    logic rd_n, wr_n, ready_n, hold_ack_out_n, bus_request_out_n, xm_data_oe;
    ebrh_pkg::ebrh_cfg_s [3:0] cfg;
    ebrh_pkg::ebrh_req_s req;
    logic [10:0] xm_addr;
    logic [15:0] xm_wdata, xm_rdata, data_in, data_out, resp_rdata, rdata;
    logic [23:0] addr_out;
    logic [3:0]  chip_select_n, rdy_dly, write_chip_select_n_n;
    logic ale, data_oe, ref_clk, wrh_n, wrl_n, share, ale_seen;
    logic [8:0]  obs;
    int cyc = 0;
    int n_errors = 0;
    int n_compared = 0;
    int t_take, t_cmd, t_rise, t_end, t_gap, t_prev, e0, c0, r0, g0, e3;
    // clock and cycle stamp used for all relative timing
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    ebrh_top i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .bus_config_reg(cfg),
        .periph_share_mode(share), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .resp_valid(resp_valid), .resp_rdata(resp_rdata), .bus_ref_clock(ref_clk),
        .addr_out(addr_out), .bus_oe(bus_oe), .data_out(data_out), .data_oe(data_oe),
        .data_in(data_in), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .write_high_strobe_n(wrh_n),
        .write_low_strobe_n(wrl_n), .write_chip_select_n(write_chip_select_n_n),
        .chip_select_n(chip_select_n), .ready_n(ready_n),
        .hold_n(hold_n), .hold_ack_out_n(hold_ack_out_n), .bus_request_out_n(bus_request_out_n),
        .xm_addr(xm_addr), .xm_rd_n(xm_rd_n), .xm_wr_n(xm_wr_n), .xm_wdata(xm_wdata),
        .xm_rdata(xm_rdata), .xm_data_oe(xm_data_oe));
    ebrh_mem_model i_mem (.sys_clk(sys_clk), .rd_n(rd_n), .wr_n(wr_n), .addr_out(addr_out),
        .data_out(data_out), .rdy_dly(rdy_dly), .data_in(data_in), .ready_n(ready_n));
    task automatic finish_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
            n_errors++;
        end
    endtask
    // a used-up wait is a mismatch and ends the run
    task automatic bounded(input int n);
        if (n >= 40) begin
            n_errors++;
            finish_test();
        end
    endtask
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    // one cycle; stamps take, strobe fall, strobe rise and end; hmid raises hold mid-cycle
    task automatic bus_op(input logic w, input logic [1:0] cs, input logic [15:0] wd,
                          input logic hmid);
        int n;
        req = '{write: w, cs: cs, addr: 24'(cs), wdata: wd, be: 2'h3};
        req_valid = 1'h1;
        t_take = 0;
        ale_seen = 1'h0;
        t_cmd = 0;
        t_rise = 0;
        t_end = 0;
        for (n = 0; n < 40 && (t_end == 0 || t_rise == 0); n++) begin
            tick();
            if (req_ready === 1'h1) begin
                t_take = cyc;
                req_valid = 1'h0;
                hold_n = !hmid;
            end
            if (ale === 1'h1) ale_seen = 1'h1;
            // strobe, lane and phase picture at the command falling edge
            if (t_take != 0 && t_cmd == 0 && (rd_n & wr_n) === 1'h0) begin
                t_cmd = cyc;
                obs = {ale_seen, ref_clk, data_oe, wrh_n, wrl_n, write_chip_select_n_n};
            end
            if (t_cmd != 0 && t_rise == 0 && (rd_n & wr_n) === 1'h1) t_rise = cyc;
            if (resp_valid === 1'h1) t_end = cyc;
            if (resp_valid === 1'h1) rdata = resp_rdata;
        end
        bounded(n);
        t_gap = t_take - t_prev;
        t_prev = t_end;
    endtask
    // hold entry, ram access by the outside master, release
    task automatic hold_seq(input logic wq);
        int n;
        logic [3:0] csl;
        csl = 4'h0;
        share = wq;
        hold_n = 1'h0;
        req_valid = wq;
        for (n = 0; n < 40 && hold_ack_out_n !== 1'h0; n++) begin
            if (bus_oe === 1'h1) csl = chip_select_n;
            tick();
        end
        bounded(n);
        chk(csl, 4'hf);
        chk(bus_oe, 1'h0);
        chk(bus_request_out_n, !wq);
        xm_addr = 11'h003;
        xm_wdata = wq ? 16'hbeef : 16'hdead;
        xm_wr_n = 1'h0;
        tick();
        xm_wr_n = 1'h1;
        tick();
        xm_rd_n = 1'h0;
        tick();
        tick();
        chk(xm_rdata, 16'hbeef);
        chk(xm_data_oe, wq);
        xm_rd_n = 1'h1;
        hold_n = 1'h1;
        for (n = 0; n < 40 && hold_ack_out_n !== 1'h1; n++) tick();
        bounded(n);
        chk(bus_oe, 1'h0);
    endtask
    initial begin
        reset_n = 1'h0;
        req_valid = 1'h0;
        req = '0;
        hold_n = 1'h1;
        xm_rd_n = 1'h1;
        xm_wr_n = 1'h1;
        xm_addr = 11'h0;
        xm_wdata = 16'h0;
        share = 1'h0;
        rdy_dly = 4'h0;
        cfg = '0;
        cfg[1].rw_delay_sel = 1'h1;
        cfg[1].mem_cycle_wait_count = 4'h2;
        cfg[2].early_write_en = 1'h1;
        cfg[2].mux_mode = 1'h1;
        cfg[2].tristate_wait_sel = 1'h1;
        cfg[3].ready_en = 1'h1;
        repeat (8) @(posedge sys_clk);
        #1 reset_n = 1'h1;
        // plain demultiplexed cycles give the reference timing
        bus_op(1'h1, 2'h0, 16'h5a3c, 1'h0);
        e0 = t_end - t_take;
        c0 = t_cmd - t_take;
        r0 = t_rise - t_end;
        chk(obs, 9'h0ce);
        bus_op(1'h0, 2'h0, 16'h0, 1'h0);
        g0 = t_gap;
        chk(obs, 9'h0bf);
        chk(rdata, 16'h5a3c);
        bus_op(1'h1, 2'h1, 16'h1111, 1'h0);
        chk(t_cmd - t_take, c0 + 1);
        chk(obs, 9'h04d);
        chk(t_end - t_take, e0 + 4);
        bus_op(1'h1, 2'h2, 16'h2222, 1'h0);
        chk(t_rise - t_end, r0 - 1);
        chk(obs, 9'h1cb);
        bus_op(1'h0, 2'h2, 16'h0, 1'h0);
        chk(t_gap, g0 + 4);
        chk(rdata, 16'h2222);
        // ready controlled cycles, synchronous then asynchronous
        bus_op(1'h0, 2'h3, 16'h0, 1'h0);
        e3 = t_end - t_take;
        rdy_dly = 4'h6;
        bus_op(1'h1, 2'h3, 16'h3333, 1'h0);
        chk(t_end - t_take > e3, 1);
        cfg[3].ready_async = 1'h1;
        rdy_dly = 4'h0;
        bus_op(1'h0, 2'h3, 16'h0, 1'h0);
        chk(rdata, 16'h3333);
        chk(t_end - t_take > e3, 1);
        // hold raised mid-cycle, then hold dropped without a pending request
        bus_op(1'h1, 2'h0, 16'h4444, 1'h1);
        hold_seq(1'h1);
        bus_op(1'h0, 2'h0, 16'h0, 1'h0);
        chk(rdata, 16'h4444);
        bus_op(1'h1, 2'h0, 16'h5555, 1'h0);
        bus_op(1'h0, 2'h0, 16'h0, 1'h0);
        chk(rdata, 16'h5555);
        hold_seq(1'h0);
        bus_op(1'h0, 2'h0, 16'h0, 1'h0);
        chk(rdata, 16'h5555);
        finish_test();
    end
endmodule
